// ===== logic/dssc_cfg.svh
// Constants for the disc sector select and CRC write block
`ifndef DSSC_CFG_SVH
`define DSSC_CFG_SVH

// Timing, printed units in ns
`define DSSC_CLK_NS         5
`define DSSC_HEAD_LOAD_NS   500000000
`define DSSC_TOUT_NS        11000000
`define DSSC_STROBE_NS      1000
`define DSSC_BIT_NS         2000

// Widths
`define DSSC_CNT_W          16
`define DSSC_SEL_W          5
`define DSSC_BYTE_W         8
`define DSSC_FIFO_DEPTH     3
`define DSSC_HL_W           27
`define DSSC_TO_W           22
`define DSSC_DIV_W          9

// Register byte offsets
`define DSSC_OFF_CTRL       5'h00
`define DSSC_OFF_STROBE1    5'h04
`define DSSC_OFF_STATUS     5'h08
`define DSSC_OFF_ADP_RS0    5'h0C
`define DSSC_OFF_ADP_RS1    5'h10

// Field positions
`define DSSC_CTRL_HLOAD     0
`define DSSC_CTRL_STEP      1
`define DSSC_CTRL_SEL_LSB   8
`define DSSC_PS1_CLR        5
`define DSSC_PS1_TOUT       6
`define DSSC_C1_SEL_LSB     6

// Reset values and CRC polynomial
`define DSSC_RD_ZERO        32'h0000_0000
`define DSSC_CRC_POLY       16'h8005
`define DSSC_CRC_ZERO       16'h0000

`endif

// ===== logic/dssc_pkg.sv
// Types for the disc sector select and CRC write block
package dssc_pkg;

    // Buffered drive status lines
    typedef struct packed {
        logic ready;
        logic write_protect;
        logic disc_change;
        logic index;
        logic sector;
        logic track_zero;
    } dssc_drive_stat_t;

    // Target of a write to adapter register select one
    typedef enum logic [1:0] {
        DSSC_AREG_CTRL2 = 2'b00,
        DSSC_AREG_CTRL3 = 2'b01,
        DSSC_AREG_SYNC  = 2'b10,
        DSSC_AREG_TXD   = 2'b11
    } dssc_areg_t;

endpackage

// ===== logic/dssc_top.sv
// Disc sector select, head load, timeout, serial adapter write path and CRC
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "dssc_cfg.svh"
// What this block does
// - Head load trigger gives half second low
// - Step signal resets the head load timer
// - Head loaded status is timer complement
// - Sixteen bit sector counter, index clears
// - First sector after index counts one
// - Five bit compare plus strobe against zero
// - Match during strobe latches sector match
// - Sector match drives write enable
// - Strobe one write with bit clears match
// - Strobe one bit six starts 11 ms timeout
// - Sector pulse delayed two stages, 1 us
// - Adapter has five write, one read register
// - Three byte transmit queue feeds shifter
// - Empty queue loads sync register, underflow
// - Two timing flops after underflow, sector clears
// - Write mode routes transmit data to CRC
// - CRC polynomial x16+x15+x2+1 appended
// - Read CRC remainder zero means valid
// - Sixteen stages, OR forms check error
// - Output enable breaks feedback, shifts remainder
// - Append switch swaps to CRC without gap
module dssc_top #(
    parameter int unsigned HEAD_LOAD_CYC = `DSSC_HEAD_LOAD_NS / `DSSC_CLK_NS,
    parameter int unsigned TOUT_CYC      = `DSSC_TOUT_NS / `DSSC_CLK_NS
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic [4:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire dssc_pkg::dssc_drive_stat_t drive_stat,
    input  wire logic                    rd_data,
    input  wire logic                    rd_bit_strobe,
    output logic                         head_loaded_n,
    output logic                         step_n,
    output logic                         timeout_irq_n,
    output logic                         sector_match,
    output logic                         wr_serial,
    output logic                         crc_output_enable,
    output logic                         crc_error
);

    localparam int unsigned STROBE_CYC = `DSSC_STROBE_NS / `DSSC_CLK_NS;
    localparam int unsigned BIT_CYC    = `DSSC_BIT_NS / `DSSC_CLK_NS;

    //------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    //------------------------------------------------------------
    // Avalon slave
    //------------------------------------------------------------
    logic        acc;
    logic        wr_acc;
    logic [31:0] wdata;
    logic [31:0] rdata_nxt;
    logic        wr_ctrl;
    logic        wr_ps1;
    logic        wr_rs0;
    logic        wr_rs1;

    assign acc    = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_acc = avs_write && !avs_waitrequest;
    assign wdata  = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_ctrl = wr_acc && (avs_address == `DSSC_OFF_CTRL);
    assign wr_ps1  = wr_acc && (avs_address == `DSSC_OFF_STROBE1);
    assign wr_rs0  = wr_acc && (avs_address == `DSSC_OFF_ADP_RS0);
    assign wr_rs1  = wr_acc && (avs_address == `DSSC_OFF_ADP_RS1);

    // One wait state per request
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_waitrequest <= 1'b1;
        end else if (acc) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Control latch
    //------------------------------------------------------------
    logic [`DSSC_SEL_W-1:0] sel_sector_r;
    logic                   step_r;
    logic                   hl_trig;

    assign hl_trig = wr_ctrl && wdata[`DSSC_CTRL_HLOAD];

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sel_sector_r <= '0;
            step_r       <= 1'b0;
        end else if (wr_ctrl) begin
            sel_sector_r <= wdata[`DSSC_CTRL_SEL_LSB +: `DSSC_SEL_W];
            step_r       <= wdata[`DSSC_CTRL_STEP];
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            step_n <= 1'b1;
        end else begin
            step_n <= !step_r;
        end
    end

    //------------------------------------------------------------
    // Head load one-shot
    //------------------------------------------------------------
    logic [`DSSC_HL_W-1:0] hl_cnt_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hl_cnt_r      <= '0;
            head_loaded_n <= 1'b1;
        end else if (step_r) begin
            hl_cnt_r      <= '0;
            head_loaded_n <= 1'b1;
        end else if (hl_trig) begin
            hl_cnt_r      <= `DSSC_HL_W'(HEAD_LOAD_CYC);
            head_loaded_n <= 1'b0;
        end else if (hl_cnt_r != '0) begin
            hl_cnt_r      <= hl_cnt_r - 1'b1;
            head_loaded_n <= (hl_cnt_r == `DSSC_HL_W'(1));
        end
    end

    //------------------------------------------------------------
    // Drive status, sector counter and strobe delay
    //------------------------------------------------------------
    dssc_pkg::dssc_drive_stat_t stat_r;
    logic                       sec_d_r;
    logic                       sec_rise;
    logic                       dly_a_r;
    logic                       dly_b_r;
    logic [8:0]                 strb_cnt_r;
    logic                       strobe_n_r;
    logic [`DSSC_CNT_W-1:0]     cur_sector_r;

    assign sec_rise = drive_stat.sector && !sec_d_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stat_r  <= '0;
            sec_d_r <= 1'b0;
            dly_a_r <= 1'b0;
            dly_b_r <= 1'b0;
        end else begin
            stat_r  <= drive_stat;
            sec_d_r <= drive_stat.sector;
            dly_a_r <= sec_rise;
            dly_b_r <= dly_a_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur_sector_r <= '0;
        end else if (drive_stat.index) begin
            cur_sector_r <= '0;
        end else if (sec_rise) begin
            cur_sector_r <= cur_sector_r + 1'b1;
        end
    end

    // Active-low strobe of 1 us after the two-stage delay
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strb_cnt_r <= '0;
            strobe_n_r <= 1'b1;
        end else if (dly_b_r) begin
            strb_cnt_r <= 9'(STROBE_CYC - 1);
            strobe_n_r <= 1'b0;
        end else if (strb_cnt_r != '0) begin
            strb_cnt_r <= strb_cnt_r - 1'b1;
        end else begin
            strobe_n_r <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // Sector compare and match latch
    //------------------------------------------------------------
    logic match_eq;
    logic match_clr;

    assign match_eq  = {sel_sector_r, 1'b0} ==
                       {cur_sector_r[`DSSC_SEL_W-1:0], strobe_n_r};
    assign match_clr = wr_ps1 && wdata[`DSSC_PS1_CLR];

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sector_match <= 1'b0;
        end else if (match_eq) begin
            sector_match <= 1'b1;
        end else if (match_clr) begin
            sector_match <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Step and load timeout
    //------------------------------------------------------------
    logic [`DSSC_TO_W-1:0] to_cnt_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            to_cnt_r      <= '0;
            timeout_irq_n <= 1'b1;
        end else if (wr_ps1 && wdata[`DSSC_PS1_TOUT]) begin
            to_cnt_r      <= `DSSC_TO_W'(TOUT_CYC);
            timeout_irq_n <= 1'b1;
        end else if (to_cnt_r != '0) begin
            to_cnt_r      <= to_cnt_r - 1'b1;
            timeout_irq_n <= (to_cnt_r != `DSSC_TO_W'(1));
        end
    end

    //------------------------------------------------------------
    // Serial adapter registers and transmit queue
    //------------------------------------------------------------
    logic [`DSSC_BYTE_W-1:0] ctrl1_r;
    logic [`DSSC_BYTE_W-1:0] ctrl2_r;
    logic [`DSSC_BYTE_W-1:0] ctrl3_r;
    logic [`DSSC_BYTE_W-1:0] sync_r;
    logic [`DSSC_BYTE_W-1:0] fifo_r [`DSSC_FIFO_DEPTH];
    logic [1:0]              fcnt_r;
    dssc_pkg::dssc_areg_t    areg;
    logic                    push;
    logic                    pop;
    logic [1:0]              wslot;

    assign areg  = dssc_pkg::dssc_areg_t'(ctrl1_r[`DSSC_C1_SEL_LSB +: 2]);
    assign push  = wr_rs1 && (areg == dssc_pkg::DSSC_AREG_TXD) &&
                   (fcnt_r != 2'(`DSSC_FIFO_DEPTH));
    assign wslot = pop ? fcnt_r - 1'b1 : fcnt_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl1_r <= '0;
            ctrl2_r <= '0;
            ctrl3_r <= '0;
            sync_r  <= '0;
        end else if (wr_rs0) begin
            ctrl1_r <= wdata[`DSSC_BYTE_W-1:0];
        end else if (wr_rs1) begin
            case (areg)
                dssc_pkg::DSSC_AREG_CTRL2: ctrl2_r <= wdata[`DSSC_BYTE_W-1:0];
                dssc_pkg::DSSC_AREG_CTRL3: ctrl3_r <= wdata[`DSSC_BYTE_W-1:0];
                dssc_pkg::DSSC_AREG_SYNC:  sync_r  <= wdata[`DSSC_BYTE_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fcnt_r <= '0;
        end else begin
            fcnt_r <= fcnt_r + 2'(push) - 2'(pop);
        end
    end

    // Bytes fall to the lowest empty slot
    for (genvar i = 0; i < `DSSC_FIFO_DEPTH; i++) begin : g_fifo
        logic [`DSSC_BYTE_W-1:0] above;
        if (i == `DSSC_FIFO_DEPTH - 1) begin : g_top
            assign above = '0;
        end else begin : g_mid
            assign above = fifo_r[i+1];
        end
        always_ff @(posedge mclk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                fifo_r[i] <= '0;
            end else if (push && (wslot == 2'(i))) begin
                fifo_r[i] <= wdata[`DSSC_BYTE_W-1:0];
            end else if (pop) begin
                fifo_r[i] <= above;
            end
        end
    end

    //------------------------------------------------------------
    // Transmit shifter, underflow and append timing
    //------------------------------------------------------------
    logic [`DSSC_DIV_W-1:0]  div_r;
    logic                    tick;
    logic [2:0]              bit_r;
    logic [`DSSC_BYTE_W-1:0] shift_r;
    logic                    load;
    logic                    underflow_r;
    logic                    tf_a_r;

    assign tick = sector_match && (div_r == '0);
    assign load = tick && (bit_r == 3'h7);
    assign pop  = load && (fcnt_r != '0);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_r <= '0;
        end else if (!sector_match || div_r == '0) begin
            div_r <= `DSSC_DIV_W'(BIT_CYC - 1);
        end else begin
            div_r <= div_r - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_r   <= 3'h7;
            shift_r <= '0;
        end else if (!sector_match) begin
            bit_r   <= 3'h7;
            shift_r <= '0;
        end else if (load) begin
            bit_r   <= 3'h0;
            shift_r <= pop ? fifo_r[0] : sync_r;
        end else if (tick) begin
            bit_r   <= bit_r + 1'b1;
            shift_r <= shift_r << 1;
        end
    end

    // Set wins over the sector clear
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            underflow_r       <= 1'b0;
            tf_a_r            <= 1'b0;
            crc_output_enable <= 1'b0;
        end else begin
            underflow_r       <= (load && !pop) || (underflow_r && !sec_rise);
            tf_a_r            <= underflow_r && !sec_rise;
            crc_output_enable <= tf_a_r && !sec_rise;
        end
    end

    //------------------------------------------------------------
    // Data switch, CRC and append switch
    //------------------------------------------------------------
    logic [15:0] crc_r;
    logic        crc_in;
    logic        crc_step;
    logic        fb;

    assign crc_in   = sector_match ? shift_r[7] : rd_data;
    assign crc_step = sector_match ? tick : rd_bit_strobe;
    assign fb       = crc_r[15] ^ crc_in;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            crc_r <= `DSSC_CRC_ZERO;
        end else if (sec_rise) begin
            crc_r <= `DSSC_CRC_ZERO;
        end else if (crc_step && crc_output_enable) begin
            crc_r <= {crc_r[14:0], 1'b0};
        end else if (crc_step) begin
            crc_r <= {crc_r[14:0], 1'b0} ^ (fb ? `DSSC_CRC_POLY : `DSSC_CRC_ZERO);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_serial <= 1'b0;
            crc_error <= 1'b0;
        end else begin
            if (tick) begin
                wr_serial <= crc_output_enable ? crc_r[15] : shift_r[7];
            end
            crc_error <= |crc_r;
        end
    end

    //------------------------------------------------------------
    // Read data
    //------------------------------------------------------------
    always_comb begin
        rdata_nxt = `DSSC_RD_ZERO;
        if (avs_address == `DSSC_OFF_CTRL) begin
            rdata_nxt[`DSSC_CTRL_STEP] = step_r;
            rdata_nxt[`DSSC_CTRL_SEL_LSB +: `DSSC_SEL_W] = sel_sector_r;
        end else if (avs_address == `DSSC_OFF_STATUS) begin
            rdata_nxt[0]     = !head_loaded_n;
            rdata_nxt[1]     = sector_match;
            rdata_nxt[2]     = crc_error;
            rdata_nxt[3]     = !timeout_irq_n;
            rdata_nxt[13:8]  = stat_r;
            rdata_nxt[31:16] = cur_sector_r;
        end else if (avs_address == `DSSC_OFF_ADP_RS0) begin
            rdata_nxt[0] = (fcnt_r == '0);
            rdata_nxt[1] = (fcnt_r == 2'(`DSSC_FIFO_DEPTH));
            rdata_nxt[2] = underflow_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= `DSSC_RD_ZERO;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdata_nxt;
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    sequence s_sec_in;
        drive_stat.sector && !sec_d_r && !drive_stat.index;
    endsequence
    sequence s_strobe_start;
        ##3 !strobe_n_r;
    endsequence

    property p_hl_load;
        @(posedge mclk) disable iff (!rst_sync_n)
        hl_trig && !step_r |=> !head_loaded_n && hl_cnt_r == `DSSC_HL_W'(HEAD_LOAD_CYC);
    endproperty
    a_hl_load: assert property (p_hl_load) else $error("head not loaded");

    property p_hl_step;
        @(posedge mclk) disable iff (!rst_sync_n)
        step_r |=> head_loaded_n && hl_cnt_r == '0;
    endproperty
    a_hl_step: assert property (p_hl_step) else $error("step kept head");

    property p_cnt;
        @(posedge mclk) disable iff (!rst_sync_n)
        s_sec_in |=> cur_sector_r == $past(cur_sector_r) + 1'b1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("sector count wrong");

    property p_idx;
        @(posedge mclk) disable iff (!rst_sync_n)
        drive_stat.index |=> cur_sector_r == '0;
    endproperty
    a_idx: assert property (p_idx) else $error("index did not clear");

    property p_dly;
        @(posedge mclk) disable iff (!rst_sync_n)
        s_sec_in |-> s_strobe_start;
    endproperty
    a_dly: assert property (p_dly) else $error("strobe not delayed");

    property p_match;
        @(posedge mclk) disable iff (!rst_sync_n)
        !strobe_n_r && sel_sector_r == cur_sector_r[`DSSC_SEL_W-1:0] |=> sector_match;
    endproperty
    a_match: assert property (p_match) else $error("match not latched");

    property p_clr;
        @(posedge mclk) disable iff (!rst_sync_n)
        match_clr && !match_eq |=> !sector_match;
    endproperty
    a_clr: assert property (p_clr) else $error("match not cleared");

    property p_tout;
        @(posedge mclk) disable iff (!rst_sync_n)
        wr_ps1 && wdata[`DSSC_PS1_TOUT] |=> timeout_irq_n && to_cnt_r != '0;
    endproperty
    a_tout: assert property (p_tout) else $error("timeout not started");

    property p_uf;
        @(posedge mclk) disable iff (!rst_sync_n)
        load && fcnt_r == '0 && !sec_rise |=> underflow_r
            ##2 (crc_output_enable || $past(sec_rise) || $past(sec_rise, 2));
    endproperty
    a_uf: assert property (p_uf) else $error("underflow path broken");

    property p_crc_clr;
        @(posedge mclk) disable iff (!rst_sync_n)
        sec_rise |=> crc_r == '0 ##1 !crc_error;
    endproperty
    a_crc_clr: assert property (p_crc_clr) else $error("crc not cleared");

endmodule // dssc_top

// ===== tb/dssc_drive_model.sv
// Behavioural flexible disc drive: status lines, index and sector pulses
`timescale 1ns/10ps
module dssc_drive_model (
    input  wire logic                 mclk,
    output dssc_pkg::dssc_drive_stat_t drive_stat
);
    // Idle drive: ready, head on track zero
    initial drive_stat = '{ready: 1'b1, track_zero: 1'b1, default: 1'b0};

    // One index or sector pulse, then quiet time past the strobe
    task automatic pulse(input logic idx);
        @(posedge mclk);
        if (idx) drive_stat.index <= 1'b1;
        else drive_stat.sector <= 1'b1;
        repeat (4) @(posedge mclk);
        drive_stat.index  <= 1'b0;
        drive_stat.sector <= 1'b0;
        repeat (300) @(posedge mclk);
    endtask
endmodule // dssc_drive_model

// ===== tb/dssc_top_test.sv
// Self-checking bench for the disc sector select block
`timescale 1ns/10ps
module dssc_top_test;
    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
    } dssc_row_t;
    logic                      mclk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [4:0]                avs_address;
    logic [31:0]               avs_writedata, avs_readdata, q;
    logic                      head_loaded_n, step_n, timeout_irq_n, sector_match;
    logic                      crc_output_enable, crc_error;
    logic                      wr_serial, rd_data, rd_bit_strobe;
    logic [3:0]                avs_byteenable;
    logic [15:0]               crc_bits;
    // Byte 0x80 followed by its check character
    localparam logic [23:0]    RD_WORD = 24'h80_8303;
    dssc_pkg::dssc_drive_stat_t drive_stat;
    int                        n_mismatch = 0;
    int                        num_checks = 0;
    dssc_row_t                 rows [6] = '{
        '{1'b1, 5'h14, 32'hFFFF_FFFF, 32'h0000_0000},
        '{1'b0, 5'h14, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 5'h04, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 5'h10, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 5'h00, 32'h0000_0300, 32'h0000_0000},
        '{1'b0, 5'h00, 32'h0000_0000, 32'h0000_0300}};

    dssc_top #(.HEAD_LOAD_CYC(50), .TOUT_CYC(80)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .drive_stat(drive_stat), .rd_data(rd_data), .rd_bit_strobe(rd_bit_strobe),
        .head_loaded_n(head_loaded_n), .step_n(step_n), .timeout_irq_n(timeout_irq_n),
        .sector_match(sector_match), .wr_serial(wr_serial),
        .crc_output_enable(crc_output_enable),
        .crc_error(crc_error));
    dssc_drive_model u_drv (.mclk(mclk), .drive_stat(drive_stat));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        results();
    end

    initial begin
        rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 5'h00; avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        rd_data = 1'b0;
        rd_bit_strobe = 1'b0;
        crc_bits = 16'h0000;
        repeat (12) @(posedge mclk);
        chk({avs_waitrequest, head_loaded_n, step_n, timeout_irq_n, sector_match,
             crc_output_enable, crc_error}, 32'h0000_0078);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) chk(q, rows[i].exp);
        end
        // Masked lane: trigger bit dropped, sector select taken
        avs_byteenable <= 4'h2;
        bus(1'b1, 5'h00, 32'h0000_1F01);
        avs_byteenable <= 4'hF;
        bus(1'b0, 5'h00, 32'h0000_0000);
        chk(q, 32'h0000_1F00);
        chk(head_loaded_n, 1'b1);
        // Head load one-shot, status copy and step reset
        bus(1'b1, 5'h00, 32'h0000_0301);
        repeat (3) @(posedge mclk);
        chk(head_loaded_n, 1'b0);
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[0], 1'b1);
        repeat (60) @(posedge mclk);
        chk(head_loaded_n, 1'b1);
        bus(1'b1, 5'h00, 32'h0000_0301);
        bus(1'b1, 5'h00, 32'h0000_0302);
        repeat (3) @(posedge mclk);
        chk({head_loaded_n, step_n}, 2'b10);
        bus(1'b1, 5'h00, 32'h0000_0300);
        // Timeout after start strobe
        bus(1'b1, 5'h04, 32'h0000_0040);
        chk(timeout_irq_n, 1'b1);
        repeat (90) @(posedge mclk);
        chk(timeout_irq_n, 1'b0);
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[3], 1'b1);
        // One byte queued for the write path
        bus(1'b1, 5'h0C, 32'h0000_00C0);
        bus(1'b1, 5'h10, 32'h0000_0080);
        bus(1'b0, 5'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        // Sector count, match on third sector, status readback
        u_drv.pulse(1'b1);
        u_drv.pulse(1'b0);
        u_drv.pulse(1'b0);
        chk(sector_match, 1'b0);
        u_drv.pulse(1'b0);
        chk(sector_match, 1'b1);
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk({q[31:16], 2'b00, q[13:8], q[1]}, 25'h000_0643);
        // Byte goes out, underflow then appends the check character
        do @(posedge mclk); while (crc_output_enable !== 1'b1);
        chk(crc_error, 1'b1);
        repeat (597) @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            crc_bits = {crc_bits[14:0], wr_serial};
            repeat (400) @(posedge mclk);
        end
        chk(crc_bits, 16'h8303);
        chk(crc_error, 1'b0);
        bus(1'b0, 5'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0005);
        bus(1'b1, 5'h04, 32'h0000_0020);
        repeat (3) @(posedge mclk);
        chk(sector_match, 1'b0);
        // Sector pulse clears append timing and CRC, then read mode check
        u_drv.pulse(1'b0);
        chk(crc_output_enable, 1'b0);
        for (int i = 23; i >= 0; i--) begin
            if (i == 15) chk(crc_error, 1'b1);
            rd_data       <= RD_WORD[i];
            rd_bit_strobe <= 1'b1;
            @(posedge mclk);
            rd_bit_strobe <= 1'b0;
            @(posedge mclk);
        end
        repeat (2) @(posedge mclk);
        chk(crc_error, 1'b0);
        results();
    end
endmodule // dssc_top_test
